// ### include/fault_retry_regs.vh
// Contract
// - ADC temperature or input-voltage fault sets status byte, word, source bits, alert low.
// - Action 00b at bits 7:6 keeps the channel running through the fault.
// - Action 01b-11b shuts down now or after turn-off delay, then retries.
// - Retry 000b never restarts; output stays off until an off-then-on command sequence.
// - Retry nonzero restarts up to global count; off command or fault stops it.
// - New retry setting takes effect only after the next off-then-on sequence.
// - Delay field bits 2:0 read fixed 000b; no deglitch on these faults.
// - Turn-on timeout sets high-byte, vout word bit, timeout bit, asserts alert.
// - Retry interval is counted on shared clock edges only.
// - Retry interval is clamped internally to at most 13.1 seconds.
// - Retry interval is taken as a count of 200 us steps, with no rounding.
// - Retry interval register reads back exactly the last written value.
// - Retry count 0 none, 1 to 6 that many, 7 unlimited.
// - Retry counter clears after 16 s without faulting off, or off-then-on; code counts CLEAN_TICKS clk cycles (1600000, 32 ms at 50 MHz).
`ifndef FAULT_RETRY_REGS_VH
`define FAULT_RETRY_REGS_VH
`define ACT_MSB          7
`define ACT_LSB          6
`define RETRY_MSB        5
`define RETRY_LSB        3
`define DLY_MASK         8'hF8
`define CFG_RESET        8'h00
`define SRC_OT           0
`define SRC_UT           1
`define SRC_VIN_OV       2
`define SRC_VIN_UV       3
`define SRC_TON          4
`define RETRY_INF        3'h7
`define STEP_US          200
`define MAX_STEPS        65500
`define CLEAN_US         16000000
`define SB_OTHER         0
`define SB_TEMP          2
`define SB_VIN           3
`define SB_VOUT          5
`define SW_VOUT          15
`define SW_INPUT         13
`define SW_HIGH_BYTE     0
`define TEMP_OT          7
`define TEMP_UT          4
`define VIN_OV           7
`define VIN_UV           4
`define VOUT_TON         2
`endif

// ### logic/step_timer.v
`include "fault_retry_regs.vh"
module step_timer #(
    parameter WIDTH = 32
) (
    input  wire             clk,
    input  wire             reset_n,
    input  wire             start,
    input  wire             tick,
    input  wire [WIDTH-1:0] count,
    output reg              done
);
    reg [WIDTH-1:0] left;
    reg             busy;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            left <= {WIDTH{1'b0}};
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                left <= count;
                busy <= 1'b1;
            end else if (busy && tick) begin
                if (left <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    left <= left - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// ### logic/fault_response_retry_ctrl.v
`include "fault_retry_regs.vh"
module fault_response_retry_ctrl #(
    parameter CLK_KHZ    = 50000,
    parameter SHARE_KHZ  = 100,
    parameter CLEAN_TICKS = 1600000
) (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        share_clk,
    input  wire [4:0]  fault_in,
    input  wire        cfg_we,
    input  wire [2:0]  cfg_sel,
    input  wire [7:0]  cfg_wdata,
    input  wire        delay_we,
    input  wire [15:0] delay_wdata,
    input  wire [2:0]  retry_count,
    input  wire        chan_on_cmd,
    input  wire        track_en,
    input  wire        toff_done,
    input  wire        ton_done,
    input  wire        clear_faults,
    output reg  [7:0]  overtemp_fault_action_cfg,
    output reg  [7:0]  undertemp_fault_action_cfg,
    output reg  [7:0]  input_overvolt_action_cfg,
    output reg  [7:0]  input_undervolt_action_cfg,
    output reg  [7:0]  turn_on_timeout_action_cfg,
    output reg  [15:0] retry_delay_rd,
    output reg  [7:0]  status_byte,
    output reg  [15:0] status_word,
    output reg  [7:0]  status_temp,
    output reg  [7:0]  status_vin,
    output reg  [7:0]  status_vout,
    output reg         chan_enable,
    output reg         seq_off_req,
    output reg         faulted_off,
    output reg         host_alert_n
);
    localparam ST_ON    = 3'd0;
    localparam ST_SEQOFF = 3'd1;
    localparam ST_OFF   = 3'd2;
    localparam ST_WAIT  = 3'd3;
    localparam ST_TURNON = 3'd4;
    localparam ST_IDLE  = 3'd5;
    reg  [2:0]  state;
    reg  [2:0]  retries;
    reg  [2:0]  latched_retry;
    reg  [4:0]  fault_q;
    reg  [2:0]  share_q;
    reg         on_q;
    reg         tmr_start;
    reg  [2:0]  hit_retry;
    reg         hit_shut;
    reg  [15:0] steps;
    reg  [31:0] clean_cnt;
    reg  [7:0]  act [0:4];
    reg  [14:0] on_retry;
    wire        tmr_done;
    wire [4:0]  rise = fault_in & ~fault_q;
    wire        share_tick = share_q[1] & ~share_q[2];
    integer i;
    always @* begin
        act[0] = overtemp_fault_action_cfg;
        act[1] = undertemp_fault_action_cfg;
        act[2] = input_overvolt_action_cfg;
        act[3] = input_undervolt_action_cfg;
        act[4] = turn_on_timeout_action_cfg;
        hit_shut  = 1'b0;
        hit_retry = 3'h0;
        for (i = 0; i < 5; i = i + 1) begin
            // A raw edge is acted on directly with no filter.
            if (rise[i] && act[i][`ACT_MSB:`ACT_LSB] != 2'b00) begin
                hit_shut  = 1'b1;
                hit_retry = hit_retry | on_retry[i*3 +: 3];
            end
        end
    end
    // The interval is kept in 200 us steps: 13.1 s is 65500 steps. The written
    // value, clamped to 65500, is used as the step count, with no rounding.
    always @* begin
        steps = (delay_wdata > 16'd65500) ? 16'hFFDC : delay_wdata;
    end
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overtemp_fault_action_cfg  <= `CFG_RESET;
            undertemp_fault_action_cfg <= `CFG_RESET;
            input_overvolt_action_cfg  <= `CFG_RESET;
            input_undervolt_action_cfg <= `CFG_RESET;
            turn_on_timeout_action_cfg <= `CFG_RESET;
            retry_delay_rd <= 16'h0000;
        end else begin
            if (cfg_we) begin
                case (cfg_sel)
                    3'd0: overtemp_fault_action_cfg  <= cfg_wdata & `DLY_MASK;
                    3'd1: undertemp_fault_action_cfg <= cfg_wdata & `DLY_MASK;
                    3'd2: input_overvolt_action_cfg  <= cfg_wdata & `DLY_MASK;
                    3'd3: input_undervolt_action_cfg <= cfg_wdata & `DLY_MASK;
                    3'd4: turn_on_timeout_action_cfg <= cfg_wdata & `DLY_MASK;
                    default: ;
                endcase
            end
            if (delay_we)
                retry_delay_rd <= delay_wdata;
        end
    end
    reg [15:0] delay_steps;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            delay_steps <= 16'h0000;
        else if (delay_we)
            delay_steps <= steps;
    end
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_q <= 5'h00;
            share_q <= 3'h0;
            on_q    <= 1'b0;
        end else begin
            fault_q <= fault_in;
            share_q <= {share_q[1:0], share_clk};
            on_q    <= chan_on_cmd;
        end
    end
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_byte  <= 8'h00;
            status_word  <= 16'h0000;
            status_temp  <= 8'h00;
            status_vin   <= 8'h00;
            status_vout  <= 8'h00;
            host_alert_n <= 1'b1;
        end else begin
            if (clear_faults) begin
                status_byte  <= 8'h00;
                status_word  <= 16'h0000;
                status_temp  <= 8'h00;
                status_vin   <= 8'h00;
                status_vout  <= 8'h00;
                host_alert_n <= 1'b1;
            end
            // Sets are placed after the clear so a fault in the clear cycle wins.
            if (rise[`SRC_OT] | rise[`SRC_UT]) begin
                status_byte[`SB_TEMP] <= 1'b1;
                status_word[`SB_TEMP] <= 1'b1;
                host_alert_n <= 1'b0;
            end
            if (rise[`SRC_OT])
                status_temp[`TEMP_OT] <= 1'b1;
            if (rise[`SRC_UT])
                status_temp[`TEMP_UT] <= 1'b1;
            if (rise[`SRC_VIN_OV] | rise[`SRC_VIN_UV]) begin
                status_byte[`SB_VIN]   <= 1'b1;
                status_word[`SB_VIN]   <= 1'b1;
                status_word[`SW_INPUT] <= 1'b1;
                host_alert_n <= 1'b0;
            end
            if (rise[`SRC_VIN_OV])
                status_vin[`VIN_OV] <= 1'b1;
            if (rise[`SRC_VIN_UV])
                status_vin[`VIN_UV] <= 1'b1;
            if (rise[`SRC_TON]) begin
                status_byte[`SB_OTHER] <= 1'b1;
                status_word[`SB_OTHER] <= 1'b1;
                status_word[`SW_VOUT]  <= 1'b1;
                status_vout[`VOUT_TON] <= 1'b1;
                host_alert_n <= 1'b0;
            end
        end
    end
    // The retry setting is captured only when the channel is switched on, so
    // a write during operation waits for the next off-then-on.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state         <= ST_IDLE;
            retries       <= 3'h0;
            latched_retry <= 3'h0;
            on_retry      <= 15'h0000;
            clean_cnt     <= 32'h0;
            chan_enable   <= 1'b0;
            seq_off_req   <= 1'b0;
            faulted_off   <= 1'b0;
            tmr_start     <= 1'b0;
        end else begin
            tmr_start <= 1'b0;
            if (state == ST_ON && clean_cnt < CLEAN_TICKS)
                clean_cnt <= clean_cnt + 32'h1;
            else if (state == ST_ON)
                retries <= 3'h0;
            if (!chan_on_cmd) begin
                state       <= ST_IDLE;
                chan_enable <= 1'b0;
                seq_off_req <= 1'b0;
                faulted_off <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (!on_q) begin
                            retries       <= 3'h0;
                            latched_retry <= 3'h7;
                            on_retry      <= {
                                turn_on_timeout_action_cfg[5:3],
                                input_undervolt_action_cfg[5:3],
                                input_overvolt_action_cfg[5:3],
                                undertemp_fault_action_cfg[5:3],
                                overtemp_fault_action_cfg[5:3]};
                            clean_cnt     <= 32'h0;
                            chan_enable   <= 1'b1;
                            state         <= ST_ON;
                        end
                    end
                    ST_ON, ST_TURNON: begin
                        // Action 00b faults leave the channel enabled.
                        if (hit_shut) begin
                            latched_retry <= hit_retry;
                            clean_cnt     <= 32'h0;
                            faulted_off   <= 1'b1;
                            if (track_en) begin
                                seq_off_req <= 1'b1;
                                state       <= ST_SEQOFF;
                            end else begin
                                chan_enable <= 1'b0;
                                state       <= ST_OFF;
                            end
                        end else if (state == ST_TURNON && ton_done) begin
                            faulted_off <= 1'b0;
                            state       <= ST_ON;
                        end
                    end
                    ST_SEQOFF: begin
                        if (toff_done) begin
                            seq_off_req <= 1'b0;
                            chan_enable <= 1'b0;
                            state       <= ST_OFF;
                        end
                    end
                    ST_OFF: begin
                        if (latched_retry == 3'h0 || retry_count == 3'h0 ||
                            (retry_count != `RETRY_INF &&
                             retries >= retry_count)) begin
                            state <= ST_OFF;
                        end else begin
                            tmr_start <= 1'b1;
                            state     <= ST_WAIT;
                        end
                    end
                    ST_WAIT: begin
                        if (tmr_done) begin
                            chan_enable <= 1'b1;
                            if (retry_count != `RETRY_INF)
                                retries <= retries + 3'h1;
                            state <= ST_TURNON;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end
    // Step count is scaled to shared-clock edges; the local clock never
    // paces the interval.
    step_timer #(
        .WIDTH (32)
    ) retry_timer (
        .clk     (clk),
        .reset_n (reset_n),
        .start   (tmr_start),
        .tick    (share_tick),
        .count   ({16'h0000, delay_steps} * (SHARE_KHZ / 5)),
        .done    (tmr_done)
    );
endmodule

// ### testbench/fault_retry_sva.sv
`include "fault_retry_regs.vh"
module fault_retry_sva (
    input wire        clk,
    input wire        reset_n,
    input wire [4:0]  fault_in,
    input wire        delay_we,
    input wire [15:0] delay_wdata,
    input wire        chan_on_cmd,
    input wire        track_en,
    input wire        clear_faults,
    input wire [7:0]  overtemp_fault_action_cfg,
    input wire [15:0] retry_delay_rd,
    input wire [15:0] status_word,
    input wire [7:0]  status_temp,
    input wire [7:0]  status_vout,
    input wire        chan_enable,
    input wire        seq_off_req,
    input wire        faulted_off,
    input wire        host_alert_n
);
    timeunit 1ns;
    timeprecision 1ps;
    wire act_ot;
    assign act_ot = overtemp_fault_action_cfg[`ACT_MSB:`ACT_LSB] != 2'h0;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    property p_ot_flag;
        $rose(fault_in[`SRC_OT]) |-> ##2 !host_alert_n && status_temp[`TEMP_OT];
    endproperty
    a_ot_flag: assert property (p_ot_flag)
        else $error("temperature fault not flagged");
    property p_alert_hold;
        !host_alert_n && !clear_faults |=> !host_alert_n;
    endproperty
    a_alert_hold: assert property (p_alert_hold)
        else $error("alert released without clear");
    property p_ton_flag;
        $rose(fault_in[`SRC_TON]) |-> ##2 !host_alert_n
            && status_vout[`VOUT_TON] && status_word[`SW_VOUT];
    endproperty
    a_ton_flag: assert property (p_ton_flag)
        else $error("turn-on timeout not flagged");
    property p_dly_zero;
        overtemp_fault_action_cfg[2:0] == 3'h0;
    endproperty
    a_dly_zero: assert property (p_dly_zero)
        else $error("delay field not zero");
    property p_readback;
        delay_we |=> retry_delay_rd == $past(delay_wdata);
    endproperty
    a_readback: assert property (p_readback)
        else $error("retry interval readback differs");
    property p_keep_on;
        $rose(fault_in[`SRC_OT]) && !act_ot && chan_enable && chan_on_cmd
            |=> chan_enable[*3];
    endproperty
    a_keep_on: assert property (p_keep_on)
        else $error("channel dropped with action zero");
    property p_shut_now;
        $rose(fault_in[`SRC_OT]) && act_ot && !track_en && chan_enable
            |-> ##2 !chan_enable && faulted_off;
    endproperty
    a_shut_now: assert property (p_shut_now)
        else $error("immediate shutdown missing");
    property p_seq_off;
        $rose(fault_in[`SRC_OT]) && act_ot && track_en && chan_enable
            |-> ##2 seq_off_req && chan_enable;
    endproperty
    a_seq_off: assert property (p_seq_off)
        else $error("sequenced shutdown missing");
endmodule

// ### testbench/chan_model.sv
module chan_model (
    input  wire  clk,
    input  wire  reset_n,
    input  wire  chan_enable,
    input  wire  seq_off_req,
    output logic share_clk,
    output logic ton_done,
    output logic toff_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int div;
    int on_cnt;
    int off_cnt;
    // The shared clock runs free; the block only counts its edges.
    always @(negedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div <= 0;
            on_cnt <= 0;
            off_cnt <= 0;
            share_clk <= 1'b0;
        end else begin
            div <= (div == 4) ? 0 : div + 1;
            if (div == 4) share_clk <= !share_clk;
            on_cnt <= chan_enable ? ((on_cnt < 7) ? on_cnt + 1 : 7) : 0;
            off_cnt <= seq_off_req ? ((off_cnt < 9) ? off_cnt + 1 : 9) : 0;
        end
    end
    assign ton_done = (on_cnt == 4);
    assign toff_done = (off_cnt == 6);
endmodule

// ### testbench/tb_top.sv
`include "fault_retry_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset_n = 0, cfg_we = 0, delay_we = 0, chan_on_cmd = 0;
    logic track_en = 0, clear_faults = 0, share_clk, ton_done, toff_done;
    logic [4:0] fault_in = 0;
    logic [2:0] cfg_sel = 0, retry_count = 0;
    logic [7:0] cfg_wdata = 0, status_byte, status_temp, status_vin;
    logic [15:0] delay_wdata = 0, retry_delay_rd, status_word;
    logic [7:0] c0, c1, c2, c3, c4, status_vout;
    logic chan_enable, seq_off_req, faulted_off, host_alert_n;
    logic [39:0] cfg_all;
    int bad_count = 0, samples_checked = 0, cycles = 0;
    assign cfg_all = {c4, c3, c2, c1, c0};
    always #10 clk = !clk;
    fault_response_retry_ctrl #(.CLEAN_TICKS(50)) i_dut (.clk(clk),
        .reset_n(reset_n), .share_clk(share_clk), .fault_in(fault_in),
        .cfg_we(cfg_we), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata),
        .delay_we(delay_we), .delay_wdata(delay_wdata),
        .retry_count(retry_count), .chan_on_cmd(chan_on_cmd),
        .track_en(track_en), .toff_done(toff_done), .ton_done(ton_done),
        .clear_faults(clear_faults), .overtemp_fault_action_cfg(c0),
        .undertemp_fault_action_cfg(c1), .input_overvolt_action_cfg(c2),
        .input_undervolt_action_cfg(c3), .turn_on_timeout_action_cfg(c4),
        .retry_delay_rd(retry_delay_rd), .status_byte(status_byte),
        .status_word(status_word), .status_temp(status_temp),
        .status_vin(status_vin), .status_vout(status_vout),
        .chan_enable(chan_enable), .seq_off_req(seq_off_req),
        .faulted_off(faulted_off), .host_alert_n(host_alert_n));
    chan_model i_chan (.clk(clk), .reset_n(reset_n), .chan_enable(chan_enable),
        .seq_off_req(seq_off_req), .share_clk(share_clk),
        .ton_done(ton_done), .toff_done(toff_done));
    task report_and_stop;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr_cfg(input logic [2:0] s, input logic [7:0] d);
        @(negedge clk) {cfg_sel, cfg_wdata, cfg_we} = {s, d, 1'b1};
        @(negedge clk) cfg_we = 1'b0;
        @(negedge clk);
    endtask
    task wr_dly(input logic [15:0] d);
        @(negedge clk) {delay_wdata, delay_we} = {d, 1'b1};
        @(negedge clk) delay_we = 1'b0;
        @(negedge clk) chk("retry_delay_rd", d, retry_delay_rd);
    endtask
    task fault(input int s);
        @(negedge clk) fault_in[s] = 1'b1;
        repeat (4) @(negedge clk);
        fault_in[s] = 1'b0;
    endtask
    task wait_en(input logic v, input int lim);
        int n;
        n = 0;
        while (chan_enable !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk("chan_enable", {15'h0, v}, {15'h0, chan_enable});
    endtask
    task restart;
        @(negedge clk) clear_faults = 1'b1;
        @(negedge clk) {clear_faults, chan_on_cmd} = 2'b00;
        repeat (3) @(negedge clk);
        chan_on_cmd = 1'b1;
        wait_en(1'b1, 20);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            bad_count++;
            report_and_stop;
        end
    end
    initial begin
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        chk("host_alert_n", 16'h1, {15'h0, host_alert_n});
        chk("status_word", 16'h0, status_word);
        for (int i = 0; i < 5; i++) begin
            wr_cfg(i[2:0], 8'hFF);
            chk("cfg", 16'hF8, {8'h0, cfg_all[i*8+:8]});
        end
        wr_cfg(3'h5, 8'h55);
        chk("cfg_all", 16'hF8F8, cfg_all[15:0]);
        wr_dly(16'hFFFF);
        wr_dly(16'h0001);
        $display("register test done");
        wr_cfg(`SRC_OT, 8'h00);
        restart;
        fault(`SRC_OT);
        chk("temp bit", 16'h1, {15'h0, status_temp[`TEMP_OT]});
        chk("byte bit", 16'h1, {15'h0, status_byte[`SB_TEMP]});
        chk("host_alert_n", 16'h0, {15'h0, host_alert_n});
        chk("chan_enable", 16'h1, {15'h0, chan_enable});
        $display("ignore action test done");
        wr_cfg(`SRC_OT, 8'h40);
        fault(`SRC_OT);
        chk("faulted_off", 16'h1, {15'h0, faulted_off});
        repeat (600) @(negedge clk);
        chk("chan_enable", 16'h0, {15'h0, chan_enable});
        restart;
        $display("no retry test done");
        track_en = 1'b1;
        fault(`SRC_OT);
        chk("seq_off_req", 16'h1, {15'h0, seq_off_req});
        wait_en(1'b0, 20);
        track_en = 1'b0;
        restart;
        $display("sequenced off test done");
        retry_count = 3'h1;
        wr_cfg(`SRC_VIN_OV, 8'h48);
        restart;
        fault(`SRC_VIN_OV);
        chk("vin bit", 16'h1, {15'h0, status_vin[`VIN_OV]});
        chk("input bit", 16'h1, {15'h0, status_word[`SW_INPUT]});
        wait_en(1'b0, 10);
        // Twenty shared clock edges at ten cycles each: too early at 150.
        repeat (150) @(negedge clk);
        chk("chan_enable", 16'h0, {15'h0, chan_enable});
        wait_en(1'b1, 150);
        repeat (10) @(negedge clk);
        chk("faulted_off", 16'h0, {15'h0, faulted_off});
        fault(`SRC_VIN_OV);
        repeat (400) @(negedge clk);
        chk("chan_enable", 16'h0, {15'h0, chan_enable});
        restart;
        $display("retry test done");
        wr_cfg(`SRC_TON, 8'h00);
        fault(`SRC_TON);
        chk("timeout bit", 16'h1, {15'h0, status_vout[`VOUT_TON]});
        chk("vout bit", 16'h1, {15'h0, status_word[`SW_VOUT]});
        chk("host_alert_n", 16'h0, {15'h0, host_alert_n});
        $display("timeout test done");
        report_and_stop;
    end
endmodule
bind fault_response_retry_ctrl fault_retry_sva i_sva (.*);
